//--- bench/hdc_testbench.sv
/*
  Self-checking bench for the holdover tuning-control block: serial writes and
  readback, rail trip bands, manual/automatic DAC, holdover entry, exit and forcing.
  Assumes the serial port is slow against i_ref_clk and that inputs are driven 1 ns after the edge.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       i_ref_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_ce = 1'b1;
  logic       i_uwire_clk = 1'b0;
  logic       i_uwire_data = 1'b0;
  logic       i_uwire_le = 1'b0;
  logic       i_lock = 1'b1;
  logic       i_pd_tick = 1'b0;
  logic       i_pump_fixed_mode = 1'b0;
  logic [9:0] i_auto_dac_code = 10'h1f4;
  logic       o_readback_data;
  logic [9:0] o_dac_code;
  logic       o_holdover;
  logic       o_switch_event;
  logic       o_input_invalid;
  logic       o_rail_low;
  logic       o_rail_high;
  logic [1:0] o_xtal;
  logic [3:0] o_c4;
  logic [3:0] o_c3;
  logic [2:0] o_r4;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         ev_cnt = 0;
  int         inv_cnt = 0;
  int         ev0;
  int         inv0;
  logic [31:0] rb;

  always #2.5 i_ref_clk = ~i_ref_clk;

  hdc_holdover_ctrl uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_uwire_clk(i_uwire_clk), .i_uwire_data(i_uwire_data), .i_uwire_le(i_uwire_le),
    .o_readback_data(o_readback_data), .i_lock(i_lock), .i_pd_tick(i_pd_tick),
    .i_pump_fixed_mode(i_pump_fixed_mode), .i_auto_dac_code(i_auto_dac_code),
    .o_dac_code(o_dac_code), .o_holdover(o_holdover), .o_switch_event(o_switch_event),
    .o_input_invalid(o_input_invalid), .o_rail_low(o_rail_low), .o_rail_high(o_rail_high),
    .o_crystal_amplitude_level(o_xtal), .o_fourth_order_capacitor_select(o_c4),
    .o_third_order_capacitor_select(o_c3), .o_fourth_order_resistor_select(o_r4)
  );

  // event pulses are tallied so a missing or doubled pulse shows as a count error
  always @(posedge i_ref_clk) begin
    if (o_switch_event === 1'b1) ev_cnt++;
    if (o_input_invalid === 1'b1) inv_cnt++;
  end

  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // msb first, clock low then high, word committed by the rising latch enable
  task automatic send(input logic [31:0] w);
    i_uwire_le = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      i_uwire_data = w[i];
      i_uwire_clk = 1'b0;
      step(2);
      i_uwire_clk = 1'b1;
      step(2);
    end
    i_uwire_clk = 1'b0;
    i_uwire_le = 1'b1;
    step(4);
  endtask : send

  // snapshot is taken at any latch, so a crystal write refreshes it without touching 23
  task automatic read_rb(output logic [31:0] v);
    send({2'h1, 25'h0, 5'h10});
    i_uwire_le = 1'b0;
    v[31] = o_readback_data;
    for (int i = 30; i >= 0; i--) begin
      i_uwire_clk = 1'b1;
      step(3);
      v[i] = o_readback_data;
      i_uwire_clk = 1'b0;
      step(2);
    end
  endtask : read_rb

  task automatic mt(input logic [9:0] man, input logic sel, input logic [13:0] cnt,
                    input logic frc);
    send({man, 1'b0, sel, cnt, frc, 5'h0f});
  endtask : mt

  task automatic tick(input int n);
    repeat (n) begin
      i_pd_tick = 1'b1;
      step(1);
      i_pd_tick = 1'b0;
      step(1);
    end
  endtask : tick

  initial begin
    step(16);
    i_rst = 1'b0;
    step(2);
    chk({o_xtal, o_c4, o_c3, o_r4, o_holdover}, 32'h0, "reset fields");
    send({4'hd, 4'hd, 1'b0, 3'h4, 15'h0, 5'h18});
    chk({o_c4, o_c3, o_r4}, {21'h0, 4'hd, 4'hd, 3'h4}, "loop filter");
    send({4'h3, 4'h7, 1'b0, 3'h2, 15'h0, 5'h19});
    chk({o_c4, o_c3, o_r4}, {21'h0, 4'hd, 4'hd, 3'h4}, "unmapped ignored");
    for (int x = 0; x < 4; x++) begin
      send({x[1:0], 25'h0, 5'h10});
      chk(o_xtal, x, "crystal level");
    end
    mt(10'h2a5, 1'b1, 14'h3, 1'b0);
    chk(o_dac_code, 10'h2a5, "manual dac");
    read_rb(rb);
    chk(rb[23:14], 10'h2a5, "readback dac");
    mt(10'h2a5, 1'b0, 14'h3, 1'b0);
    chk(o_dac_code, 10'h1f4, "auto dac");
    i_ce = 1'b0;
    i_auto_dac_code = 10'h155;
    step(3);
    chk(o_dac_code, 10'h1f4, "enable low freezes dac");
    i_ce = 1'b1;
    i_auto_dac_code = 10'h1f4;
    ev0 = ev_cnt;
    i_lock = 1'b0;
    step(2);
    chk({o_holdover, 31'(ev_cnt - ev0)}, {1'b1, 31'h1}, "lock loss entry");
    send({16'h0, 1'b1, 10'h0, 5'h0d});
    i_lock = 1'b1;
    tick(2);
    i_lock = 1'b0;
    step(2);
    i_lock = 1'b1;
    tick(2);
    step(3);
    chk(o_holdover, 1'b1, "counter restart");
    tick(1);
    step(2);
    chk(o_holdover, 1'b0, "exit after count");
    ev0 = ev_cnt;
    i_lock = 1'b0;
    step(3);
    chk({o_holdover, 31'(ev_cnt - ev0)}, 32'h0, "masked lock loss");
    i_lock = 1'b1;
    send({16'h0, 1'b0, 10'h0, 5'h0d});
    i_pump_fixed_mode = 1'b1;
    ev0 = ev_cnt;
    mt(10'h123, 1'b0, 14'h1, 1'b1);
    chk({o_holdover, 31'(ev_cnt - ev0)}, {1'b1, 31'h1}, "force event");
    chk(o_dac_code, 10'h123, "forced fixed dac");
    tick(5);
    step(2);
    chk(o_holdover, 1'b1, "force holds");
    mt(10'h123, 1'b0, 14'h1, 1'b0);
    tick(1);
    step(2);
    chk(o_holdover, 1'b0, "force cleared");
    send({16'h0, 1'b1, 10'h0, 5'h0d});
    i_pump_fixed_mode = 1'b0;
    i_auto_dac_code = 10'h1c7;
    ev0 = ev_cnt;
    mt(10'h123, 1'b0, 14'h1, 1'b1);
    i_auto_dac_code = 10'h0aa;
    step(3);
    chk({o_dac_code, 22'(ev_cnt - ev0)}, {10'h1c7, 22'h0}, "tracked force");
    mt(10'h123, 1'b0, 14'h1, 1'b0);
    tick(1);
    step(2);
    send({12'h0, 6'h02, 2'h0, 6'h05, 1'b0, 5'h0e});
    ev0 = ev_cnt;
    inv0 = inv_cnt;
    i_auto_dac_code = 10'd96;
    step(3);
    chk(o_rail_low, 1'b0, "above low trip");
    i_auto_dac_code = 10'd95;
    step(3);
    chk(o_rail_low, 1'b1, "at low trip");
    i_auto_dac_code = 10'd975;
    step(3);
    chk(o_rail_high, 1'b0, "below high trip");
    i_auto_dac_code = 10'd976;
    step(3);
    chk(o_rail_high, 1'b1, "at high trip");
    chk({o_holdover, 31'(ev_cnt - ev0 + inv_cnt - inv0)}, 32'h0, "rail disabled");
    i_auto_dac_code = 10'd500;
    send({12'h0, 6'h02, 2'h0, 6'h05, 1'b1, 5'h0e});
    i_auto_dac_code = 10'd976;
    step(3);
    chk({o_holdover, 15'(ev_cnt - ev0), 16'(inv_cnt - inv0)}, {1'b1, 15'h1, 16'h1},
        "rail trip");
    conclude();
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : testbench
`default_nettype wire

//--- hw/hdc_holdover_ctrl.sv
/*
  Holdover and tuning-DAC control with its serial programming registers.
  Assumes all inputs synchronous to i_ref_clk; i_pd_tick pulses once per
  reference-loop phase-detector period; the serial clock is much slower than i_ref_clk.
*/
// Behaviour
// R1: six-bit low trip code n sets railed-low level at (n+1)/64 of supply.
// R2: six-bit high trip code sets level (n+1)/64 below supply; sets flags.
// R3: rail enable set: trip marks input invalid and raises switch event.
// R4: ten-bit manual value n drives DAC to n/1023 of supply.
// R5: select bit 0 runs DAC automatically, 1 uses manual value.
// R6: leave holdover only after lock holds for programmed tick count.
// R7: force bit keeps holdover regardless of lock.
// R8: forced holdover uses manual value in fixed mode, else holds tracked.
// R9: forcing raises switch event only when lock-loss mask is clear.
// R10: falling lock raises switch event when mask clear, not when set.
// R11: software never writes register 23; it only reads it.
// R12: readback bits 23 to 14 hold the tracked DAC value.
// R13: two-bit crystal amplitude field is stored.
// R14: four-bit fourth-order capacitor field is stored.
// R15: four-bit third-order capacitor field is stored.
// R16: three-bit fourth-order resistor field is stored.
// R17: exit counter restarts from zero whenever lock drops early.
`timescale 1ns/10ps
`default_nettype none
module hdc_holdover_ctrl (
  // clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // serial programming port
  input  wire logic        i_uwire_clk,
  input  wire logic        i_uwire_data,
  input  wire logic        i_uwire_le,
  output logic             o_readback_data,
  // loop status
  input  wire logic        i_lock,
  input  wire logic        i_pd_tick,
  input  wire logic        i_pump_fixed_mode,
  input  wire logic [9:0]  i_auto_dac_code,
  // tuning and events
  output logic [9:0]       o_dac_code,
  output logic             o_holdover,
  output logic             o_switch_event,
  output logic             o_input_invalid,
  output logic             o_rail_low,
  output logic             o_rail_high,
  // analog settings
  output logic [1:0]       o_crystal_amplitude_level,
  output logic [3:0]       o_fourth_order_capacitor_select,
  output logic [3:0]       o_third_order_capacitor_select,
  output logic [2:0]       o_fourth_order_resistor_select
);
  logic [31:0] shift_reg;
  logic [31:0] rb_shift_reg;
  logic        sclk_q_reg;
  logic        le_q_reg;
  logic [5:0]  low_rail_trip_code;
  logic [5:0]  high_rail_trip_code;
  logic        rail_detect_enable;
  logic [9:0]  manual_tuning_value;
  logic        manual_tuning_select;
  logic [13:0] holdover_exit_count;
  logic        force_reg;
  logic        lock_loss_switch_mask;
  logic [13:0] exit_cnt_reg;
  logic        lock_q_reg;
  logic        force_q_reg;
  logic        railed_q_reg;
  logic [9:0]  dac_next;
  hdc_pkg::hdc_state_e state_reg, state_next;

  wire logic        sclk_rise = i_uwire_clk & ~sclk_q_reg;
  wire logic        le_rise   = i_uwire_le & ~le_q_reg;
  wire logic [4:0]  addr      = shift_reg[hdc_pkg::ADDR_W-1:0];
  wire logic [15:0] dac_x64   = {o_dac_code, 6'h00};
  wire logic [15:0] low_lim   = 16'(({10'h000, low_rail_trip_code} + 16'h0001)
                                    * hdc_pkg::DAC_FULL_SCALE);
  wire logic [15:0] high_lim  = 16'((hdc_pkg::TRIP_TOP_CODE - {10'h000, high_rail_trip_code})
                                    * hdc_pkg::DAC_FULL_SCALE);
  wire logic rail_low   = dac_x64 <= low_lim;   // see R1
  wire logic rail_high  = dac_x64 >= high_lim;  // see R2
  wire logic railed     = rail_low | rail_high;
  wire logic rail_trip  = rail_detect_enable & railed & ~railed_q_reg;  // see R3
  wire logic lock_fall  = lock_q_reg & ~i_lock;
  wire logic lock_evt   = lock_fall & ~lock_loss_switch_mask;  // see R10
  wire logic force_rise = force_reg & ~force_q_reg;
  wire logic force_evt  = force_rise & ~lock_loss_switch_mask;  // see R9
  // a reserved zero count behaves like one tick
  wire logic [13:0] exit_target = (holdover_exit_count == 14'h0000) ? 14'h0001
                                                                    : holdover_exit_count;
  wire logic exit_done  = exit_cnt_reg >= exit_target;

  // serial shifter; the word is acted on at the rising edge of the latch enable
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      shift_reg  <= 32'h0000_0000;
      sclk_q_reg <= 1'b0;
      le_q_reg   <= 1'b0;
    end else if (i_ce) begin
      sclk_q_reg <= i_uwire_clk;
      le_q_reg   <= i_uwire_le;
      if (sclk_rise && !i_uwire_le) begin
        shift_reg <= {shift_reg[30:0], i_uwire_data};
      end
    end
  end

  // register writes; the readback register has no storage so a write to it is dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      low_rail_trip_code              <= hdc_pkg::RST_TRIP;
      high_rail_trip_code             <= hdc_pkg::RST_TRIP;
      rail_detect_enable              <= 1'b0;
      manual_tuning_value             <= hdc_pkg::RST_MAN_VALUE;
      manual_tuning_select            <= 1'b0;
      holdover_exit_count             <= hdc_pkg::RST_EXIT_COUNT;
      force_reg                       <= 1'b0;
      lock_loss_switch_mask           <= 1'b0;
      o_crystal_amplitude_level       <= hdc_pkg::RST_XTAL;
      o_fourth_order_capacitor_select <= hdc_pkg::RST_CAP;
      o_third_order_capacitor_select  <= hdc_pkg::RST_CAP;
      o_fourth_order_resistor_select  <= hdc_pkg::RST_RES;
    end else if (i_ce && le_rise) begin
      case (addr)
        hdc_pkg::REG_LOCK_SWITCH: begin
          lock_loss_switch_mask <= shift_reg[hdc_pkg::LOCK_MASK_BIT];
        end
        hdc_pkg::REG_RAIL_DETECT: begin
          low_rail_trip_code  <= shift_reg[hdc_pkg::LOW_TRIP_LSB +: 6];   // see R1
          high_rail_trip_code <= shift_reg[hdc_pkg::HIGH_TRIP_LSB +: 6];  // see R2
          rail_detect_enable  <= shift_reg[hdc_pkg::RAIL_EN_BIT];
        end
        hdc_pkg::REG_MANUAL_TUNE: begin
          manual_tuning_value  <= shift_reg[hdc_pkg::MAN_VALUE_LSB +: 10];  // see R4
          manual_tuning_select <= shift_reg[hdc_pkg::MAN_SELECT_BIT];
          holdover_exit_count  <= shift_reg[hdc_pkg::EXIT_COUNT_LSB +: 14];
          force_reg            <= shift_reg[hdc_pkg::FORCE_BIT];
        end
        hdc_pkg::REG_CRYSTAL: begin
          o_crystal_amplitude_level <= shift_reg[hdc_pkg::XTAL_LSB +: 2];  // see R13
        end
        hdc_pkg::REG_LOOP_FILTER: begin
          o_fourth_order_capacitor_select <= shift_reg[hdc_pkg::C4_LSB +: 4];  // see R14
          o_third_order_capacitor_select  <= shift_reg[hdc_pkg::C3_LSB +: 4];  // see R15
          o_fourth_order_resistor_select  <= shift_reg[hdc_pkg::R4_LSB +: 3];  // see R16
        end
        default: begin
        end
      endcase
    end
  end

  // readback snapshot taken at every latch, then shifted out msb first
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rb_shift_reg    <= 32'h0000_0000;
      o_readback_data <= 1'b0;
    end else if (i_ce) begin
      if (le_rise) begin
        rb_shift_reg <= {8'h00, o_dac_code, 14'h0000};  // see R12
      end else if (sclk_rise && !i_uwire_le) begin
        rb_shift_reg <= {rb_shift_reg[30:0], 1'b0};
      end
      o_readback_data <= rb_shift_reg[31];
    end
  end

  // holdover state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hdc_pkg::HDC_TRACK: begin
        if (force_reg || rail_trip || lock_evt) begin
          state_next = hdc_pkg::HDC_HOLDOVER;
        end
      end
      hdc_pkg::HDC_HOLDOVER: begin
        if (!force_reg && !rail_trip && exit_done) begin  // see R6, R7
          state_next = hdc_pkg::HDC_TRACK;
        end
      end
      default: state_next = hdc_pkg::HDC_TRACK;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg    <= hdc_pkg::HDC_TRACK;
      lock_q_reg   <= 1'b0;
      force_q_reg  <= 1'b0;
      railed_q_reg <= 1'b0;
      o_holdover   <= 1'b0;
    end else if (i_ce) begin
      state_reg    <= state_next;
      lock_q_reg   <= i_lock;
      force_q_reg  <= force_reg;
      railed_q_reg <= railed;
      o_holdover   <= state_next == hdc_pkg::HDC_HOLDOVER;
    end
  end

  // exit counter only advances on phase-detector ticks while lock stays valid
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      exit_cnt_reg <= 14'h0000;
    end else if (i_ce) begin
      if (state_reg != hdc_pkg::HDC_HOLDOVER || !i_lock) begin
        exit_cnt_reg <= 14'h0000;  // see R17
      end else if (i_pd_tick && exit_cnt_reg != hdc_pkg::EXIT_MAX) begin
        exit_cnt_reg <= exit_cnt_reg + 14'h0001;  // see R6
      end
    end
  end

  // tuning dac: manual overrides all; holdover freezes the tracked code, except forced holdover in fixed mode drives the manual value
  always_comb begin
    dac_next = o_dac_code;
    if (manual_tuning_select) begin
      dac_next = manual_tuning_value;  // see R5
    end else if (state_reg == hdc_pkg::HDC_HOLDOVER) begin
      if (force_reg && i_pump_fixed_mode) begin
        dac_next = manual_tuning_value;  // see R8
      end
    end else begin
      dac_next = i_auto_dac_code;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dac_code      <= 10'h000;
      o_switch_event  <= 1'b0;
      o_input_invalid <= 1'b0;
      o_rail_low      <= 1'b0;
      o_rail_high     <= 1'b0;
    end else if (i_ce) begin
      o_dac_code      <= dac_next;
      o_switch_event  <= rail_trip | lock_evt | force_evt;  // see R3, R9, R10
      o_input_invalid <= rail_trip;  // see R3
      o_rail_low      <= rail_low;
      o_rail_high     <= rail_high;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_low_flag: assert property (i_ce && rail_low |=> o_rail_low)  // see R1
    else $error("low rail flag missing");
  a_high_flag: assert property (i_ce && rail_high |=> o_rail_high)  // see R2
    else $error("high rail flag missing");
  a_rail_event: assert property (i_ce && rail_trip |=> o_switch_event && o_input_invalid) // see R3
    else $error("rail trip gave no switch event");
  a_rail_disabled: assert property (i_ce && !rail_detect_enable |=> !o_input_invalid)  // see R3
    else $error("input invalid while rail detect off");
  a_manual_drive: assert property (i_ce && manual_tuning_select  // see R4
                                   |=> o_dac_code == $past(manual_tuning_value))
    else $error("manual value not driven");
  a_auto_track: assert property (i_ce && !manual_tuning_select  // see R5
                                 && state_reg == hdc_pkg::HDC_TRACK
                                 |=> o_dac_code == $past(i_auto_dac_code))
    else $error("automatic code not tracked");
  a_no_early_exit: assert property (i_ce && state_reg == hdc_pkg::HDC_HOLDOVER  // see R6
                                    && !exit_done |=> state_reg == hdc_pkg::HDC_HOLDOVER)
    else $error("holdover left before count");
  a_force_holds: assert property (i_ce && force_reg |=> o_holdover)  // see R7
    else $error("forced holdover not held");
  a_fixed_force: assert property (i_ce && state_reg == hdc_pkg::HDC_HOLDOVER  // see R8
                                  && force_reg && i_pump_fixed_mode && !manual_tuning_select
                                  |=> o_dac_code == $past(manual_tuning_value))
    else $error("fixed forced holdover lost manual value");
  a_force_masked: assert property (i_ce && force_rise && lock_loss_switch_mask  // see R9
                                   && !rail_trip && !lock_fall |=> !o_switch_event)
    else $error("masked force raised switch event");
  a_lock_event: assert property (i_ce && lock_fall && !lock_loss_switch_mask  // see R10
                                 |=> o_switch_event)
    else $error("lock loss gave no switch event");
  a_exit_restart: assert property (i_ce && state_reg == hdc_pkg::HDC_HOLDOVER  // see R17
                                   && !i_lock |=> exit_cnt_reg == 14'h0000)
    else $error("exit counter not restarted");
  a_readback_load: assert property (i_ce && le_rise  // see R12
                                    |=> rb_shift_reg[23:14] == $past(o_dac_code))
    else $error("readback not loaded with dac code");
  a_filter_store: assert property (i_ce && le_rise && addr == hdc_pkg::REG_LOOP_FILTER // see R14
                                   |=> o_fourth_order_capacitor_select == $past(shift_reg[31:28])
                                   && o_third_order_capacitor_select == $past(shift_reg[27:24])
                                   && o_fourth_order_resistor_select == $past(shift_reg[22:20]))
    else $error("loop filter fields not stored");
  a_crystal_store: assert property (i_ce && le_rise && addr == hdc_pkg::REG_CRYSTAL  // see R13
                                    |=> o_crystal_amplitude_level == $past(shift_reg[31:30]))
    else $error("crystal field not stored");

  c_force_entry: cover property (i_ce && force_rise ##1 state_reg == hdc_pkg::HDC_HOLDOVER);
  c_lock_exit: cover property (state_reg == hdc_pkg::HDC_HOLDOVER
                               ##1 state_reg == hdc_pkg::HDC_TRACK);
  c_rail_trip: cover property (i_ce && rail_trip);
  c_lock_switch: cover property (i_ce && lock_evt);
endmodule : hdc_holdover_ctrl
`default_nettype wire

//--- hw/hdc_pkg.sv
/*
  Constants for the holdover tuning-control block: register numbers, field positions,
  reset values and the scaling used by the tuning-rail comparators.
  Assumes a 32-bit serial word with the register number in its low five bits.
*/
package hdc_pkg;
  // register numbers carried in word[4:0]
  localparam logic [4:0] REG_LOCK_SWITCH  = 5'h0d;
  localparam logic [4:0] REG_RAIL_DETECT  = 5'h0e;
  localparam logic [4:0] REG_MANUAL_TUNE  = 5'h0f;
  localparam logic [4:0] REG_CRYSTAL      = 5'h10;
  localparam logic [4:0] REG_READBACK     = 5'h17;
  localparam logic [4:0] REG_LOOP_FILTER  = 5'h18;
  localparam int         ADDR_W           = 5;
  // field positions (lsb)
  localparam int LOCK_MASK_BIT   = 15;
  localparam int LOW_TRIP_LSB    = 6;
  localparam int HIGH_TRIP_LSB   = 14;
  localparam int RAIL_EN_BIT     = 5;
  localparam int MAN_VALUE_LSB   = 22;
  localparam int MAN_SELECT_BIT  = 20;
  localparam int EXIT_COUNT_LSB  = 6;
  localparam int FORCE_BIT       = 5;
  localparam int XTAL_LSB        = 30;
  localparam int C4_LSB          = 28;
  localparam int C3_LSB          = 24;
  localparam int R4_LSB          = 20;
  localparam int READBACK_LSB    = 14;
  // reset values
  localparam logic [5:0]  RST_TRIP       = 6'h00;
  localparam logic [9:0]  RST_MAN_VALUE  = 10'h000;
  localparam logic [13:0] RST_EXIT_COUNT = 14'h0001;
  localparam logic [1:0]  RST_XTAL       = 2'h0;
  localparam logic [3:0]  RST_CAP        = 4'h0;
  localparam logic [2:0]  RST_RES        = 3'h0;
  // rail scaling: code n is (n+1)/64 of the rail, dac code k is k/1023 of it
  localparam logic [15:0] DAC_FULL_SCALE = 16'h03ff;
  localparam logic [15:0] TRIP_TOP_CODE  = 16'h003f;
  localparam logic [13:0] EXIT_MAX       = 14'h3fff;

  typedef enum logic [0:0] {HDC_TRACK, HDC_HOLDOVER} hdc_state_e;
endpackage : hdc_pkg
